// [common/csp_pkg.sv]
`default_nettype none
package csp_pkg;
    // bus identity and high-speed controller code (0000_1xxx)
    localparam logic [6:0] DEV_ADDR      = 7'h35;
    localparam logic [4:0] HS_CODE       = 5'h01;
    // register locations
    localparam logic [7:0] ADR_INT_MASK  = 8'h01;
    localparam logic [7:0] ADR_SUMMARY   = 8'h02;
    localparam logic [7:0] ADR_IN_THERM  = 8'h03;
    localparam logic [7:0] ADR_BATT      = 8'h04;
    localparam logic [7:0] ADR_IN_CTRL   = 8'h05;
    localparam logic [7:0] ADR_FCHG      = 8'h06;
    localparam logic [7:0] ADR_ILIM      = 8'h07;
    localparam logic [7:0] ADR_TERM      = 8'h08;
    localparam logic [7:0] ADR_TREG      = 8'h09;
    localparam logic [7:0] ADR_PROT      = 8'h0a;
    localparam logic [7:0] ADR_INT_REQ   = 8'h0f;
    localparam logic [3:0] ADR_PAGE0     = 4'h0;
    localparam int         REG_SLOTS     = 16;
    // reset values
    localparam logic [7:0] RST_INT_REQ   = 8'h01;
    localparam logic [7:0] RST_INT_MASK  = 8'h00;
    localparam logic [7:0] RST_CTRL      = 8'h00;
    // writable bits of each read/write register
    localparam logic [7:0] WM_INT_MASK   = 8'hfe;
    localparam logic [7:0] WM_IN_CTRL    = 8'h03;
    localparam logic [7:0] WM_FCHG       = 8'hff;
    localparam logic [7:0] WM_ILIM       = 8'h7f;
    localparam logic [7:0] WM_TERM       = 8'hff;
    localparam logic [7:0] WM_TREG       = 8'hc9;
    localparam logic [7:0] WM_PROT       = 8'h0c;
    // defined bits of the read-only registers
    localparam logic [7:0] RM_SUMMARY    = 8'hfe;
    localparam logic [7:0] RM_IN_THERM   = 8'hf7;
    localparam logic [7:0] RM_BATT       = 8'h3f;
    // interrupt request bits
    localparam logic [7:0] POWERUP_FLAG  = 8'h01;
    localparam logic [7:0] IRQ_SRC_MASK  = 8'hfe;
    // serial framing
    localparam logic [3:0] LAST_BIT      = 4'h7;
    localparam logic [3:0] ACK_BIT       = 4'h8;
    localparam logic [3:0] CNT_STEP      = 4'h1;
    localparam logic [7:0] PTR_STEP      = 8'h01;
    localparam logic       SDA_LOW       = 1'b0;

    typedef struct packed {
        logic [7:0] summary_status;
        logic [7:0] input_thermal_detail;
        logic [7:0] battery_charge_detail;
    } csp_status_t;

    typedef struct packed {
        logic [7:0] interrupt_mask;
        logic [7:0] input_control;
        logic [7:0] fast_charge_setting;
        logic [7:0] input_current_limit;
        logic [7:0] termination_control;
        logic [7:0] temperature_regulation;
        logic [7:0] protection_lock;
    } csp_config_t;

    typedef enum logic [2:0] {
        LS_ADDR,
        LS_PTR,
        LS_WDATA,
        LS_RDATA,
        LS_IGNORE
    } csp_link_state_t;
endpackage : csp_pkg
`default_nettype wire

// [src/csp_serial_port.sv]
// Notes on behaviour
// - port works with bus clock from 0 to 100 kHz or 400 kHz
// - device never holds scl low; controller sets every clock period
// - filters start in standard/fast setting at power-up and after stop
// - only the high-speed controller code moves filters to high-speed setting
// - stop returns filters to slow setting; repeated start keeps them
// - start then 7-bit address plus direction; match is acked low
// - after write address, pointer byte is acked and kept
// - each write byte is acked and loaded at the ack rising edge
// - any number of write bytes may follow, each acked
// - last byte of a multi-byte write is acked too
// - successive bytes go to consecutive registers from the pointer
// - after read address ack, eight bits from pointed register go out
// - controller ack asks for next byte; nack ends the sending
// - registers reset on standby supply loss or power-good rising edge
// - mask 0x01, status 0x02-0x04, control 0x05-0x0a, requests 0x0f
// - only address 011 0101 answers, bytes 0x6a and 0x6b
// - general call address is not acknowledged
// - after stop or foreign address, clock ignored until next start
// - request flags show changes since last read; read clears them
`default_nettype none
module csp_serial_port (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 scl_link,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe,
    input  wire logic                 standby_supply_valid,
    input  wire logic                 safe_out_power_good,
    input  wire csp_pkg::csp_status_t status_i,
    input  wire logic [7:0]           irq_event,
    output csp_pkg::csp_config_t      config_o,
    output logic [7:0]                interrupt_requests,
    output logic                      hs_filter_en
);
    import csp_pkg::*;

    // clk domain state
    logic [1:0]      scl_sq;
    logic [1:0]      sda_sq;
    logic [1:0]      stby_sq;
    logic [1:0]      pok_sq;
    logic            sda_p_q;
    logic            pok_p_q;
    csp_status_t     stat_s1_q;
    csp_status_t     stat_q;
    logic            start_d_q;
    logic            run_q;
    logic            hs_q;
    logic [2:0]      wr_sq;
    logic [2:0]      rd_sq;
    logic [2:0]      hs_sq;
    logic [7:0]      regs_q [REG_SLOTS];
    logic [7:0]      irq_q;
    logic [7:0]      rd_byte_q;

    // link domain state
    csp_link_state_t st_q;
    csp_link_state_t st_nx;
    logic [3:0]      cnt_q;
    logic [6:0]      sh_q;
    logic [7:0]      byte_q;
    logic            ack_q;
    logic [7:0]      ptr_q;
    logic            wr_tg_q;
    logic            rd_tg_q;
    logic            hs_tg_q;
    logic [7:0]      wr_addr_q;
    logic [7:0]      wr_data_q;
    logic [7:0]      rd_addr_q;
    logic            sda_oe_q;
    logic [6:0]      tx_q;

    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            ADR_INT_MASK: wmask = WM_INT_MASK;
            ADR_IN_CTRL:  wmask = WM_IN_CTRL;
            ADR_FCHG:     wmask = WM_FCHG;
            ADR_ILIM:     wmask = WM_ILIM;
            ADR_TERM:     wmask = WM_TERM;
            ADR_TREG:     wmask = WM_TREG;
            ADR_PROT:     wmask = WM_PROT;
            default:      wmask = '0;
        endcase
    endfunction : wmask

    function automatic logic [7:0] rd_sel(
        input logic [7:0]  a,
        input csp_status_t s,
        input logic [7:0]  irq,
        input logic [7:0]  rw
    );
        case (a)
            ADR_SUMMARY:  rd_sel = s.summary_status & RM_SUMMARY;
            ADR_IN_THERM: rd_sel = s.input_thermal_detail & RM_IN_THERM;
            ADR_BATT:     rd_sel = s.battery_charge_detail & RM_BATT;
            ADR_INT_REQ:  rd_sel = irq;
            default:      rd_sel = rw & wmask(a);
        endcase
    endfunction : rd_sel

    // ---------------- clk domain ----------------
    wire start_det = scl_sq[1] & sda_p_q & ~sda_sq[1];
    wire stop_det  = scl_sq[1] & ~sda_p_q & sda_sq[1];
    wire run_d     = ~start_det & ~stop_det & (run_q | start_d_q);
    // link held in reset from stop to next start, and briefly at each start
    wire link_rst_n = arst_n & run_q;
    wire pok_rise  = pok_sq[1] & ~pok_p_q;
    wire soft_rst  = ~stby_sq[1] | pok_rise;
    wire wr_evt    = wr_sq[1] ^ wr_sq[2];
    wire rd_evt    = rd_sq[1] ^ rd_sq[2];
    wire hs_evt    = hs_sq[1] ^ hs_sq[2];
    wire wr_hit    = wr_addr_q[7:4] == ADR_PAGE0;
    wire rd_int    = rd_evt & (rd_addr_q == ADR_INT_REQ);
    wire [7:0] irq_set = (irq_event & IRQ_SRC_MASK)
                       | (soft_rst ? POWERUP_FLAG : '0);
    // set wins over a read clearing the same bit
    wire [7:0] irq_clr = rd_int ? irq_q : '0;
    wire [7:0] irq_d   = soft_rst ? RST_INT_REQ
                       : (irq_q & ~irq_clr) | irq_set;
    wire [7:0] rw_rd   = (rd_addr_q[7:4] == ADR_PAGE0)
                       ? regs_q[rd_addr_q[3:0]] : '0;
    wire [7:0] rd_mux  = rd_sel(rd_addr_q, stat_q, irq_q, rw_rd);

    // scl, sda and analog-side levels are asynchronous here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sq    <= '1;
            sda_sq    <= '1;
            stby_sq   <= '1;
            pok_sq    <= '0;
            sda_p_q   <= 1'b1;
            pok_p_q   <= 1'b0;
            stat_s1_q <= '0;
            stat_q    <= '0;
        end else begin
            scl_sq    <= {scl_sq[0], scl_link};
            sda_sq    <= {sda_sq[0], sda_i};
            stby_sq   <= {stby_sq[0], standby_supply_valid};
            pok_sq    <= {pok_sq[0], safe_out_power_good};
            sda_p_q   <= sda_sq[1];
            pok_p_q   <= pok_sq[1];
            stat_s1_q <= status_i;
            stat_q    <= stat_s1_q;
        end
    end

    // toggles from the link domain, two stages then an edge stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_sq <= '0;
            rd_sq <= '0;
            hs_sq <= '0;
        end else begin
            wr_sq <= {wr_sq[1:0], wr_tg_q};
            rd_sq <= {rd_sq[1:0], rd_tg_q};
            hs_sq <= {hs_sq[1:0], hs_tg_q};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_d_q <= 1'b0;
            run_q     <= 1'b0;
            hs_q      <= 1'b0;
        end else begin
            start_d_q <= start_det;
            run_q     <= run_d;
            if (stop_det) begin
                hs_q <= 1'b0;
            end else if (hs_evt) begin
                hs_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < REG_SLOTS; i++) begin
                regs_q[i] <= RST_CTRL;
            end
        end else if (soft_rst) begin
            for (int i = 0; i < REG_SLOTS; i++) begin
                regs_q[i] <= RST_CTRL;
            end
        end else if (wr_evt && wr_hit) begin
            regs_q[wr_addr_q[3:0]] <=
                wr_data_q & wmask(wr_addr_q);
        end
    end

    // read data is fetched a few clk cycles after the ack rising edge and
    // must be ready by the next scl fall; scl high time covers that
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q     <= RST_INT_REQ;
            rd_byte_q <= '0;
        end else begin
            irq_q <= irq_d;
            if (rd_evt) begin
                rd_byte_q <= rd_mux;
            end
        end
    end

    assign config_o.interrupt_mask         = regs_q[ADR_INT_MASK[3:0]];
    assign config_o.input_control          = regs_q[ADR_IN_CTRL[3:0]];
    assign config_o.fast_charge_setting    = regs_q[ADR_FCHG[3:0]];
    assign config_o.input_current_limit    = regs_q[ADR_ILIM[3:0]];
    assign config_o.termination_control    = regs_q[ADR_TERM[3:0]];
    assign config_o.temperature_regulation = regs_q[ADR_TREG[3:0]];
    assign config_o.protection_lock        = regs_q[ADR_PROT[3:0]];
    assign interrupt_requests              = irq_q;
    assign hs_filter_en                    = hs_q;

    // ---------------- link domain (scl) ----------------
    wire [7:0] byte_w   = {sh_q, sda_i};
    // a zero general-call byte never matches
    wire adr_hit        = byte_w[7:1] == DEV_ADDR;
    wire hs_code        = byte_w[7:3] == HS_CODE;
    wire last_bit       = cnt_q == LAST_BIT;
    wire ack_bit        = cnt_q == ACK_BIT;
    wire master_ack     = ~sda_i;
    wire in_addr        = st_q == LS_ADDR;
    wire in_rd          = st_q == LS_RDATA;
    wire ack_want       = in_addr ? adr_hit
                        : (st_q == LS_PTR) | (st_q == LS_WDATA);
    wire do_ptr         = ack_bit & (st_q == LS_PTR);
    wire do_wr          = ack_bit & (st_q == LS_WDATA);
    wire rd_first       = ack_bit & in_addr & ack_q & byte_q[0];
    wire rd_next        = ack_bit & in_rd & master_ack;
    wire do_hs          = last_bit & in_addr & hs_code;

    always_comb begin
        case (st_q)
            LS_ADDR: begin
                if (!ack_q) begin
                    st_nx = LS_IGNORE;
                end else if (byte_q[0]) begin
                    st_nx = LS_RDATA;
                end else begin
                    st_nx = LS_PTR;
                end
            end
            LS_PTR:   st_nx = LS_WDATA;
            LS_WDATA: st_nx = LS_WDATA;
            LS_RDATA: st_nx = master_ack ? LS_RDATA : LS_IGNORE;
            default:  st_nx = LS_IGNORE;
        endcase
    end

    // every timing edge is the controller's scl; nothing here holds it
    always_ff @(posedge scl_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_q   <= LS_ADDR;
            cnt_q  <= '0;
            sh_q   <= '0;
            byte_q <= '0;
            ack_q  <= 1'b0;
        end else begin
            cnt_q <= ack_bit ? '0 : cnt_q + CNT_STEP;
            if (!ack_bit) begin
                sh_q <= byte_w[6:0];
            end
            if (last_bit) begin
                byte_q <= byte_w;
                ack_q  <= ack_want;
            end
            if (ack_bit) begin
                st_q <= st_nx;
            end
        end
    end

    // pointer and handoff words survive repeated start and stop
    always_ff @(posedge scl_link or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q     <= '0;
            wr_tg_q   <= 1'b0;
            rd_tg_q   <= 1'b0;
            hs_tg_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            rd_addr_q <= '0;
        end else begin
            if (do_ptr) begin
                ptr_q <= byte_q;
            end else if (do_wr || (ack_bit && in_rd)) begin
                ptr_q <= ptr_q + PTR_STEP;
            end
            if (do_wr) begin
                wr_addr_q <= ptr_q;
                wr_data_q <= byte_q;
                wr_tg_q   <= ~wr_tg_q;
            end
            if (rd_first) begin
                rd_addr_q <= ptr_q;
                rd_tg_q   <= ~rd_tg_q;
            end else if (rd_next) begin
                rd_addr_q <= ptr_q + PTR_STEP;
                rd_tg_q   <= ~rd_tg_q;
            end
            if (do_hs) begin
                hs_tg_q <= ~hs_tg_q;
            end
        end
    end

    // sda changes only while scl is low
    always_ff @(negedge scl_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe_q <= 1'b0;
            tx_q     <= '0;
        end else if (in_rd && cnt_q == '0) begin
            tx_q     <= rd_byte_q[6:0];
            sda_oe_q <= ~rd_byte_q[7];
        end else if (in_rd && !ack_bit) begin
            tx_q     <= {tx_q[5:0], SDA_LOW};
            sda_oe_q <= ~tx_q[6];
        end else begin
            sda_oe_q <= ack_bit & ack_q & ~in_rd;
        end
    end

    assign sda_o  = SDA_LOW;
    assign sda_oe = sda_oe_q;

    // ---------------- checks ----------------
    a_stop_filter:
    assert property (@(posedge clk) disable iff (!arst_n)
        stop_det |=> !hs_q)
    else $error("filters not back to standard after stop");

    a_hs_cause:
    assert property (@(posedge clk) disable iff (!arst_n)
        $rose(hs_q) |-> $past(hs_evt))
    else $error("high-speed filters set without controller code");

    a_powerup_reset:
    assert property (@(posedge clk) disable iff (!arst_n)
        soft_rst |=> irq_q[0] && config_o.interrupt_mask == RST_INT_MASK
                     && config_o.protection_lock == RST_CTRL)
    else $error("registers not reset by supply event");

    a_read_clears:
    assert property (@(posedge clk) disable iff (!arst_n)
        rd_int && !soft_rst
        |=> (irq_q & $past(irq_q) & ~$past(irq_event)) == '0)
    else $error("request flags not cleared by read");

    a_reserved_zero:
    assert property (@(posedge clk) disable iff (!arst_n)
        ((config_o.input_control & ~WM_IN_CTRL)
        | (config_o.temperature_regulation & ~WM_TREG)
        | (config_o.interrupt_mask & ~WM_INT_MASK)) == '0)
    else $error("reserved bit became set");

    a_write_lands:
    assert property (@(posedge clk) disable iff (!arst_n)
        wr_evt && wr_addr_q == ADR_FCHG && !soft_rst
        |=> config_o.fast_charge_setting == $past(wr_data_q))
    else $error("written byte not loaded");

    a_addr_ack:
    assert property (@(posedge scl_link) disable iff (!link_rst_n)
        in_addr && last_bit && adr_hit |=> ack_q && ack_bit)
    else $error("own address not acknowledged");

    a_no_gc_ack:
    assert property (@(posedge scl_link) disable iff (!link_rst_n)
        in_addr && last_bit && byte_w == '0
        |=> !ack_q ##1 st_q == LS_IGNORE)
    else $error("general call acknowledged");

    a_ptr_advance:
    assert property (@(posedge scl_link) disable iff (!arst_n)
        do_wr |=> ptr_q == $past(ptr_q) + PTR_STEP)
    else $error("pointer did not advance after write byte");

    a_ignore_quiet:
    assert property (@(negedge scl_link) disable iff (!link_rst_n)
        st_q == LS_IGNORE && $past(st_q) == LS_IGNORE |-> !sda_oe_q)
    else $error("sda driven while ignoring the bus");
endmodule : csp_serial_port
`default_nettype wire

// [verification/csp_bus_ctrl.sv]
`default_nettype none
module csp_bus_ctrl (
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // fast-mode top rate by default; a test may slow it down
    time half = 1250ns;

    // only this side makes scl, and it idles high between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // serves as start and as repeated start
    task automatic start_c;
        sda_rel = 1'b1;
        #(half / 2);
        scl = 1'b1;
        #(half);
        sda_rel = 1'b0;
        #(half);
        scl = 1'b0;
    endtask : start_c

    task automatic stop_c;
        #(half / 4);
        sda_rel = 1'b0;
        #(half * 3 / 4);
        scl = 1'b1;
        #(half);
        sda_rel = 1'b1;
        #(half);
    endtask : stop_c

    // data moves a quarter of the low time after scl falls, clear of the edge
    task automatic bit_c(input logic b, output logic s);
        #(half / 4);
        sda_rel = b;
        #(half * 3 / 4);
        s = sda;
        scl = 1'b1;
        #(half);
        scl = 1'b0;
    endtask : bit_c

    // released bits read back what the device drives
    task automatic byte_c(input logic [7:0] tx, input logic ack_tx,
                          output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_c(tx[i], rx[i]);
        end
        bit_c(ack_tx, ack_rx);
    endtask : byte_c
endmodule : csp_bus_ctrl
`default_nettype wire

// [verification/charger_serial_register_port_test.sv]
`default_nettype none
module charger_serial_register_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import csp_pkg::*;

    logic        clk                  = 1'b0;
    logic        arst_n               = 1'b0;
    logic        standby_supply_valid = 1'b1;
    logic        safe_out_power_good  = 1'b0;
    csp_status_t status_i             = '0;
    logic [7:0]  irq_event            = 8'h00;
    logic        scl;
    logic        sda_rel;
    logic        sda_o;
    logic        sda_oe;
    logic        hs_filter_en;
    csp_config_t config_o;
    logic [7:0]  interrupt_requests;
    int          err_total            = 0;
    int          n_compared           = 0;
    logic [7:0]  rq[$];
    logic [7:0]  eq[$];

    // open-drain data line with its pull-up
    wire logic sda_line = sda_rel & ~(sda_oe & ~sda_o);

    always #20 clk = ~clk;

    csp_serial_port DUT (
        .clk                 (clk),
        .arst_n              (arst_n),
        .scl_link            (scl),
        .sda_i               (sda_line),
        .sda_o               (sda_o),
        .sda_oe              (sda_oe),
        .standby_supply_valid(standby_supply_valid),
        .safe_out_power_good (safe_out_power_good),
        .status_i            (status_i),
        .irq_event           (irq_event),
        .config_o            (config_o),
        .interrupt_requests  (interrupt_requests),
        .hs_filter_en        (hs_filter_en)
    );

    csp_bus_ctrl bus (
        .scl    (scl),
        .sda_rel(sda_rel),
        .sda    (sda_line)
    );

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic       a;
        bus.byte_c(b, 1'b1, rx, a);
        check("ack", a, exp_ack);
    endtask : send

    task automatic wr(input logic [7:0] ptr, input logic [7:0] q[$]);
        bus.start_c();
        send({DEV_ADDR, 1'b0}, SDA_LOW);
        send(ptr, SDA_LOW);
        foreach (q[i]) send(q[i], SDA_LOW);
        bus.stop_c();
    endtask : wr

    task automatic rd(input logic [7:0] ptr, input int n,
                      output logic [7:0] q[$]);
        logic [7:0] b;
        logic       a;
        q = {};
        bus.start_c();
        send({DEV_ADDR, 1'b0}, SDA_LOW);
        send(ptr, SDA_LOW);
        bus.start_c();
        send({DEV_ADDR, 1'b1}, SDA_LOW);
        for (int i = 0; i < n; i++) begin
            bus.byte_c(8'hff, i == n - 1, b, a);
            q.push_back(b);
        end
        bus.stop_c();
    endtask : rd

    task automatic cmpq(input string what);
        check("read count", rq.size(), eq.size());
        foreach (eq[i]) check(what, rq[i], eq[i]);
    endtask : cmpq

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        status_i = '{8'h5b, 8'hcc, 8'h3d};
        repeat (4) @(negedge clk);
        check("requests at reset", interrupt_requests, RST_INT_REQ);
        check("config at reset", config_o, '0);
        check("filter at reset", hs_filter_en, 1'b0);
        $display("test reset done");

        // registers 0x01 to 0x0a written, read-only and reserved bits must stay put
        wr(ADR_INT_MASK, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                           8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
        check("config masks", config_o, {WM_INT_MASK, WM_IN_CTRL, WM_FCHG,
              WM_ILIM, WM_TERM, WM_TREG, WM_PROT});
        check("filter plain", hs_filter_en, 1'b0);
        rd(ADR_INT_MASK, 10, rq);
        eq = '{WM_INT_MASK, 8'h5b & RM_SUMMARY, 8'hcc & RM_IN_THERM,
               8'h3d & RM_BATT, WM_IN_CTRL, WM_FCHG, WM_ILIM, WM_TERM,
               WM_TREG, WM_PROT};
        cmpq("sequential read");
        $display("test sequential done");

        // standard-mode rate, single byte each way
        bus.half = 5000;
        wr(ADR_FCHG, '{8'ha5});
        check("single write", config_o.fast_charge_setting, 8'ha5);
        rd(ADR_FCHG, 1, rq);
        eq = '{8'ha5};
        cmpq("single read");
        rd(8'h0b, 1, rq);
        eq = '{8'h00};
        cmpq("gap read");
        bus.half = 1250;
        $display("test single done");

        // foreign, general call and neighbour addresses stay unanswered
        eq.delete();
        for (int i = 0; i < 3; i++) begin
            bus.start_c();
            send({i == 0 ? 7'h36 : i == 1 ? 7'h00 : 7'h34, 1'b0},
                 1'b1);
            send(ADR_IN_CTRL, 1'b1);
            send(8'h00, 1'b1);
            bus.stop_c();
        end
        check("ignored write", config_o.input_control, WM_IN_CTRL);
        $display("test refused done");

        // high-speed code, kept across repeated start, dropped by stop
        bus.start_c();
        send({HS_CODE, 3'b000}, 1'b1);
        check("filter after code", hs_filter_en, 1'b1);
        bus.start_c();
        send({DEV_ADDR, 1'b0}, SDA_LOW);
        send(ADR_TREG, SDA_LOW);
        send(8'h00, SDA_LOW);
        bus.start_c();
        check("filter after restart", hs_filter_en, 1'b1);
        bus.stop_c();
        check("filter after stop", hs_filter_en, 1'b0);
        check("reg in fast", config_o.temperature_regulation, 8'h00);
        $display("test filter done");

        // request flags collect events and clear on read
        @(negedge clk) irq_event = 8'h82;
        @(negedge clk) irq_event = 8'h00;
        repeat (2) @(negedge clk);
        check("flags set", interrupt_requests,
              POWERUP_FLAG | 8'h82);
        rd(ADR_INT_REQ, 1, rq);
        eq = '{POWERUP_FLAG | 8'h82};
        cmpq("flags read");
        check("flags cleared", interrupt_requests, 8'h00);
        $display("test flags done");

        // supply loss, then power-good rising edge
        @(negedge clk) standby_supply_valid = 1'b0;
        repeat (6) @(negedge clk);
        standby_supply_valid = 1'b1;
        repeat (6) @(negedge clk);
        check("standby config", config_o, '0);
        check("standby flags", interrupt_requests, RST_INT_REQ);
        wr(ADR_PROT, '{8'hff});
        check("prot set", config_o.protection_lock, WM_PROT);
        @(negedge clk) safe_out_power_good = 1'b1;
        repeat (8) @(negedge clk);
        check("power-good config", config_o, '0);
        check("power-good flags", interrupt_requests, RST_INT_REQ);
        $display("test soft reset done");
        test_done();
    end

    // about 100k cycles, well past the expected run
    initial begin
        #4ms;
        err_total++;
        $display("ERROR watchdog expected end seen hang");
        test_done();
    end
endmodule : charger_serial_register_port_test
`default_nettype wire
